// >>> rtl/swire_pkg.sv
// types shared by the single-wire slave
package swire_pkg;

	// ==========================================================
	// selection state machine
	typedef enum logic [3:0] {
		ST_SLEEP = 4'h0,
		ST_PRES_WAIT = 4'h1,
		ST_PRES_DRIVE = 4'h2,
		ST_ROM_CMD = 4'h3,
		ST_MATCH = 4'h4,
		ST_SRCH_BIT = 4'h5,
		ST_SRCH_CMP = 4'h6,
		ST_SRCH_DIR = 4'h7,
		ST_FUNC = 4'h8
	} sel_state_t;

endpackage

// >>> rtl/swire_regs.svh
// timing, command and width constants for the single-wire slave
//
// What this block does
// - match command compares 64 bits to identity
// - mismatching device sleeps until next reset
// - skip command goes straight to function
// - search sends bit, complement, takes direction
// - after reset rise wait, then presence low
// - ready for data after presence and recovery
// - each slot carries exactly one bit
// - slot timer starts at falling crossing
// - recovery time needed after rising crossing
// - read zero drives low, read one silent
// - falling edge detection is low-pass filtered
// - shallow glitch above hysteresis is ignored
// - glitches inside hold-off window are ignored
// - long low line resets the device
// - selection commands are eight bits after presence
`ifndef SWIRE_REGS_SVH
`define SWIRE_REGS_SVH

// ==========================================================
// clock and times
`define SW_CLK_MHZ 50
`define SW_FILT_NS 100
`define SW_HOLDOFF_NS 500
`define SW_SAMPLE_US 30
`define SW_READ_HOLD_US 25
`define SW_PRESENCE_HIGH_DELAY_US 30
`define SW_PRESENCE_LOW_TIME_US 120
`define SW_RESET_DETECT_US 240

// least times round up to whole cycles
`define SW_FILT_CYC ((`SW_FILT_NS * `SW_CLK_MHZ + 999) / 1000)
`define SW_HOLDOFF_CYC ((`SW_HOLDOFF_NS * `SW_CLK_MHZ + 999) / 1000)
`define SW_SAMPLE_CYC (`SW_SAMPLE_US * `SW_CLK_MHZ)
`define SW_READ_HOLD_CYC (`SW_READ_HOLD_US * `SW_CLK_MHZ)
`define SW_PDH_CYC (`SW_PRESENCE_HIGH_DELAY_US * `SW_CLK_MHZ)
`define SW_PDL_CYC (`SW_PRESENCE_LOW_TIME_US * `SW_CLK_MHZ)
`define SW_RST_CYC (`SW_RESET_DETECT_US * `SW_CLK_MHZ)

// ==========================================================
// counter widths
`define SW_FILT_W 4
`define SW_HOLD_W 6
`define SW_SLOT_W 12
`define SW_PRES_W 16
`define SW_LOW_W 16
`define SW_IDX_W 6
`define SW_ID_LAST 6'h3f
`define SW_BIT_LAST 3'h7

// ==========================================================
// selection commands
`define SW_CMD_MATCH 8'h55
`define SW_CMD_SKIP 8'hcc
`define SW_CMD_SEARCH 8'hf0

`endif

// >>> rtl/swire_slave.sv
// single-wire slave: front end, slot timing, presence and selection
`timescale 1ns/1ns
`include "swire_regs.svh"

module swire_slave #(
	parameter logic [63:0] DEVICE_ID = 64'h3c5a_7e19_0b2d_46a1, // arbitrary value
	parameter int PDL_CYC = `SW_PDL_CYC,
	parameter int RST_CYC = `SW_RST_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic dq_lo_in,
	input wire logic dq_hi_in,
	output logic dq_out,
	output logic dq_oe,
	output logic selected,
	output logic func_valid,
	output logic [7:0] func_byte,
	output logic bus_reset
);

	// ==========================================================
	// state
	swire_pkg::sel_state_t state_q;
	swire_pkg::sel_state_t state_d;
	logic lvl_q;
	logic [`SW_FILT_W-1:0] lo_cnt_q;
	logic [`SW_HOLD_W-1:0] hold_q;
	logic fall_q;
	logic slot_act_q;
	logic [`SW_SLOT_W-1:0] slot_cnt_q;
	logic bit_done_q;
	logic bit_q;
	logic rd_drive_q;
	logic oe_q;
	logic [`SW_LOW_W-1:0] low_cnt_q;
	logic rst_seen_q;
	logic [`SW_PRES_W-1:0] pres_cnt_q;
	logic [`SW_IDX_W-1:0] idx_q;
	logic [2:0] bitn_q;
	logic [7:0] sh_q;
	logic fv_q;
	logic [7:0] fb_q;
	logic sel_q;
	logic brst_q;

	// ==========================================================
	// decode
	logic pres_phase;
	logic fall_d;
	logic rise_d;
	logic long_low;
	logic id_bit;
	logic tx_bit;
	logic read_st;
	logic [7:0] rx_byte;
	logic oe_d;
	logic id_last;
	logic byte_last;
	logic pdh_done;
	logic pdl_done;

	// our own presence drive must not be seen as a master slot
	assign pres_phase = (state_q == swire_pkg::ST_PRES_WAIT) || (state_q == swire_pkg::ST_PRES_DRIVE);
	// a fall counts only after the low level persisted and hold-off ended
	assign fall_d = lvl_q && !pres_phase && (hold_q == '0)
		&& (lo_cnt_q == `SW_FILT_W'(`SW_FILT_CYC));
	// leaving low needs the upper switchpoint, leaving high the lower one
	assign rise_d = !lvl_q && dq_hi_in;
	// the releasing edge is no longer a long low, so that rise can start presence
	assign long_low = !lvl_q && !dq_hi_in && (low_cnt_q >= `SW_LOW_W'(RST_CYC));
	assign id_bit = DEVICE_ID[idx_q];
	assign tx_bit = (state_q == swire_pkg::ST_SRCH_CMP) ? ~id_bit : id_bit;
	assign read_st = (state_q == swire_pkg::ST_SRCH_BIT) || (state_q == swire_pkg::ST_SRCH_CMP);
	assign rx_byte = {bit_q, sh_q[7:1]};
	assign oe_d = (state_q == swire_pkg::ST_PRES_DRIVE) || rd_drive_q;
	assign id_last = (idx_q == `SW_ID_LAST);
	assign byte_last = (bitn_q == `SW_BIT_LAST);
	assign pdh_done = (pres_cnt_q == `SW_PRES_W'(`SW_PDH_CYC - 1));
	assign pdl_done = (pres_cnt_q == `SW_PRES_W'(PDL_CYC - 1));

	// ==========================================================
	// analog front end in digital form
	// lo_cnt is the low-pass filter on the slot-start edge
	// our own pulldown restarts it, or the tail of presence would open a false slot
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			lo_cnt_q <= '0;
		end else if (!dq_lo_in || oe_q) begin
			lo_cnt_q <= '0;
		end else if (lo_cnt_q != `SW_FILT_W'(`SW_FILT_CYC)) begin
			lo_cnt_q <= lo_cnt_q + `SW_FILT_W'(1);
		end
	end

	// recognised level with hysteresis
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			lvl_q <= 1'b1;
		end else if (fall_d) begin
			lvl_q <= 1'b0;
		end else if (rise_d) begin
			lvl_q <= 1'b1;
		end
	end

	// hold-off window opened by each rising crossing
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			hold_q <= '0;
		end else if (rise_d) begin
			hold_q <= `SW_HOLD_W'(`SW_HOLDOFF_CYC);
		end else if (hold_q != '0) begin
			hold_q <= hold_q - `SW_HOLD_W'(1);
		end
	end

	// ==========================================================
	// slot timer, one bit per slot
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			fall_q <= 1'b0;
			slot_act_q <= 1'b0;
			slot_cnt_q <= '0;
			bit_done_q <= 1'b0;
			bit_q <= 1'b0;
		end else begin
			fall_q <= fall_d;
			bit_done_q <= 1'b0;
			if (fall_d) begin
				slot_act_q <= 1'b1;
				slot_cnt_q <= `SW_SLOT_W'(1);
			end else if (slot_act_q) begin
				slot_cnt_q <= slot_cnt_q + `SW_SLOT_W'(1);
				if (slot_cnt_q == `SW_SLOT_W'(`SW_SAMPLE_CYC)) begin
					slot_act_q <= 1'b0;
					bit_done_q <= 1'b1;
					bit_q <= lvl_q;
				end
			end
		end
	end

	// read-zero pulldown timed by the slot timer; a one leaves the line alone
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rd_drive_q <= 1'b0;
		end else if (fall_d && read_st && !tx_bit) begin
			rd_drive_q <= 1'b1;
		end else if (slot_cnt_q == `SW_SLOT_W'(`SW_READ_HOLD_CYC)) begin
			rd_drive_q <= 1'b0;
		end
	end

	// ==========================================================
	// long-low reset detection
	// a low held past the limit abandons whatever was in progress
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			low_cnt_q <= '0;
		end else if (lvl_q) begin
			low_cnt_q <= '0;
		end else if (!long_low) begin
			low_cnt_q <= low_cnt_q + `SW_LOW_W'(1);
		end
	end

	// ==========================================================
	// selection state machine
	always_comb begin
		state_d = state_q;
		if (long_low) begin
			state_d = swire_pkg::ST_SLEEP;
		end else if (rise_d && rst_seen_q) begin
			state_d = swire_pkg::ST_PRES_WAIT;
		end else begin
			unique case (state_q)
				swire_pkg::ST_SLEEP: begin
					state_d = swire_pkg::ST_SLEEP;
				end
				swire_pkg::ST_PRES_WAIT: begin
					if (pdh_done) state_d = swire_pkg::ST_PRES_DRIVE;
				end
				swire_pkg::ST_PRES_DRIVE: begin
					if (pdl_done) state_d = swire_pkg::ST_ROM_CMD;
				end
				swire_pkg::ST_ROM_CMD: begin
					if (bit_done_q && byte_last) begin
						if (rx_byte == `SW_CMD_MATCH) state_d = swire_pkg::ST_MATCH;
						else if (rx_byte == `SW_CMD_SKIP) state_d = swire_pkg::ST_FUNC;
						else if (rx_byte == `SW_CMD_SEARCH) state_d = swire_pkg::ST_SRCH_BIT;
						else state_d = swire_pkg::ST_SLEEP;
					end
				end
				swire_pkg::ST_MATCH: begin
					if (bit_done_q) begin
						if (bit_q != id_bit) state_d = swire_pkg::ST_SLEEP;
						else if (id_last) state_d = swire_pkg::ST_FUNC;
					end
				end
				swire_pkg::ST_SRCH_BIT: begin
					if (bit_done_q) state_d = swire_pkg::ST_SRCH_CMP;
				end
				swire_pkg::ST_SRCH_CMP: begin
					if (bit_done_q) state_d = swire_pkg::ST_SRCH_DIR;
				end
				swire_pkg::ST_SRCH_DIR: begin
					if (bit_done_q) begin
						if (bit_q != id_bit) state_d = swire_pkg::ST_SLEEP;
						else if (id_last) state_d = swire_pkg::ST_FUNC;
						else state_d = swire_pkg::ST_SRCH_BIT;
					end
				end
				swire_pkg::ST_FUNC: begin
					state_d = swire_pkg::ST_FUNC;
				end
				default: begin
					state_d = swire_pkg::ST_SLEEP;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_q <= swire_pkg::ST_SLEEP;
		end else begin
			state_q <= state_d;
		end
	end

	// reset seen flag and presence timing
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rst_seen_q <= 1'b0;
			pres_cnt_q <= '0;
		end else begin
			if (long_low) rst_seen_q <= 1'b1;
			else if (rise_d) rst_seen_q <= 1'b0;
			if (state_d != state_q) pres_cnt_q <= '0;
			else if (pres_phase) pres_cnt_q <= pres_cnt_q + `SW_PRES_W'(1);
		end
	end

	// bit and byte counters, shift register taking bits lsb first
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			idx_q <= '0;
			bitn_q <= '0;
			sh_q <= '0;
		end else if (pres_phase) begin
			idx_q <= '0;
			bitn_q <= '0;
		end else if (bit_done_q) begin
			sh_q <= rx_byte;
			bitn_q <= bitn_q + 3'h1;
			if (state_q == swire_pkg::ST_MATCH || state_q == swire_pkg::ST_SRCH_DIR) begin
				idx_q <= idx_q + `SW_IDX_W'(1);
			end
		end
	end

	// ==========================================================
	// registered outputs
	// selection holds until the next bus reset, function bytes pulse once
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			oe_q <= 1'b0;
			fv_q <= 1'b0;
			fb_q <= '0;
			sel_q <= 1'b0;
			brst_q <= 1'b0;
		end else begin
			oe_q <= oe_d;
			brst_q <= rise_d && rst_seen_q;
			sel_q <= (state_d == swire_pkg::ST_FUNC);
			fv_q <= bit_done_q && byte_last && (state_q == swire_pkg::ST_FUNC);
			if (bit_done_q && byte_last && state_q == swire_pkg::ST_FUNC) fb_q <= rx_byte;
		end
	end

	assign dq_out = 1'b0;
	assign dq_oe = oe_q;
	assign selected = sel_q;
	assign func_valid = fv_q;
	assign func_byte = fb_q;
	assign bus_reset = brst_q;

	// ==========================================================
	// checks
	match_miss_sleep_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state_q == swire_pkg::ST_MATCH && bit_done_q && bit_q != id_bit && !long_low)
		|=> state_q == swire_pkg::ST_SLEEP) else $error("match mismatch did not sleep");

	skip_to_func_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state_q == swire_pkg::ST_ROM_CMD && bit_done_q && byte_last && rx_byte == `SW_CMD_SKIP
		&& !long_low && !(rise_d && rst_seen_q)) |=> selected) else $error("skip did not select");

	search_seq_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state_q == swire_pkg::ST_SRCH_BIT && bit_done_q && !long_low && !(rise_d && rst_seen_q))
		|=> state_q == swire_pkg::ST_SRCH_CMP) else $error("search bit not followed by complement");

	search_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state_q == swire_pkg::ST_SRCH_DIR && bit_done_q && bit_q != id_bit)
		|=> !read_st ##1 !selected) else $error("search loser kept going");

	presence_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
		(state_q == swire_pkg::ST_PRES_WAIT && state_d == swire_pkg::ST_PRES_DRIVE)
		|=> ##1 dq_oe [*8]) else $error("presence pulse missing");

	write_no_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
		(fall_q && !read_st && !pres_phase) |-> ##2 !dq_oe) else $error("drove line in write slot");

	slot_start_a: assert property (@(posedge mclk) disable iff (!rstn)
		fall_q |-> slot_act_q && slot_cnt_q == `SW_SLOT_W'(1)) else $error("slot timer not started");

	holdoff_block_a: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(lvl_q) |-> !fall_d [*8]) else $error("fall accepted inside hold-off");

	filter_fall_a: assert property (@(posedge mclk) disable iff (!rstn)
		fall_d |-> $past(dq_lo_in, 4) && $past(dq_lo_in, 1)) else $error("unfiltered fall accepted");

	hyst_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
		(lvl_q && !dq_lo_in) |=> lvl_q) else $error("shallow glitch changed level");

	long_low_a: assert property (@(posedge mclk) disable iff (!rstn)
		long_low |=> state_q == swire_pkg::ST_SLEEP && !selected) else $error("long low did not reset");

endmodule // swire_slave

// >>> sim/swire_master.sv
// bus master model that drives the single-wire line for the bench
`timescale 1ns/1ns

module swire_master #(
	parameter int RESET_LOW_CYC = 2100 // outlasts the slave's shortened long-low limit
) (
	input wire logic mclk,
	input wire logic dq_oe,
	output logic dq_lo_in,
	output logic dq_hi_in
);
	// ==========================================================
	// line model
	localparam int SLOT_CYC = 1560;
	logic pull = 1'b0;
	logic shallow = 1'b0;
	logic line;

	// the pullup wins whenever nobody pulls, so a released line never keeps a stale low
	assign line = ~(pull | dq_oe);
	assign dq_lo_in = ~line;
	assign dq_hi_in = line & ~shallow; // a shallow dip only leaves the upper switchpoint

	// ==========================================================
	// reset pulse, then look for the presence answer
	task automatic bus_reset_pulse(output logic early_hi, output logic pres);
		pull <= 1'b1;
		repeat (RESET_LOW_CYC) @(posedge mclk);
		pull <= 1'b0;
		repeat (1000) @(posedge mclk);
		early_hi = line;
		repeat (600) @(posedge mclk);
		pres = ~line;
		repeat (800) @(posedge mclk);
	endtask

	// ==========================================================
	// one time slot; the loop pads every slot to full length for recovery
	task automatic slot(input logic wbit, output logic rbit);
		rbit = 1'b1;
		pull <= 1'b1;
		for (int i = 1; i < SLOT_CYC; i++) begin
			@(posedge mclk);
			if (i == (wbit ? 10 : 1520))
				pull <= 1'b0;
			if (i == 500)
				rbit = line;
		end
	endtask

	// a whole byte, one bit per slot
	task automatic send_byte(input logic [7:0] b);
		logic r;
		for (int i = 0; i < 8; i++)
			slot(b[i], r);
	endtask

	// noise between slots: deep short spike or shallow dip
	task automatic glitch(input int n, input logic deep);
		if (deep)
			pull <= 1'b1;
		else
			shallow <= 1'b1;
		repeat (n) @(posedge mclk);
		pull <= 1'b0;
		shallow <= 1'b0;
		repeat (100) @(posedge mclk);
	endtask
endmodule // swire_master

// >>> sim/tb_top.sv
// self-checking bench for the single-wire slave
`timescale 1ns/1ns

module tb_top;
	// ==========================================================
	// signals and instances
	localparam logic [63:0] DEV_ID = 64'h9e37_21c4_5b08_d6f3; // arbitrary value
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic dq_lo_in, dq_hi_in, dq_out, dq_oe, selected, func_valid, bus_reset;
	logic [7:0] func_byte;
	logic [7:0] last_byte;
	int err_count = 0;
	int cmp_count = 0;
	int n_reset = 0;
	int n_func = 0;

	// free-running 50 MHz clock
	initial begin
		forever #10 mclk = ~mclk;
	end

	// short presence and reset limit keep the run short; the limit still outlasts a write-zero low
	swire_slave #(.DEVICE_ID(DEV_ID), .PDL_CYC(200), .RST_CYC(1800)) DUT (
		.mclk(mclk), .rstn(rstn), .dq_lo_in(dq_lo_in), .dq_hi_in(dq_hi_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .selected(selected), .func_valid(func_valid), .func_byte(func_byte),
		.bus_reset(bus_reset));

	swire_master mst (
		.mclk(mclk), .dq_oe(dq_oe), .dq_lo_in(dq_lo_in), .dq_hi_in(dq_hi_in));

	// one-cycle pulses are counted here so no task can miss them
	always @(posedge mclk) begin
		if (bus_reset === 1'b1)
			n_reset++;
		if (func_valid === 1'b1) begin
			n_func++;
			last_byte = func_byte;
		end
	end

	// ==========================================================
	// checking and closing
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic do_reset();
		logic early_hi;
		logic pres;
		int nr;
		nr = n_reset;
		mst.bus_reset_pulse(early_hi, pres);
		chk("bus_reset count", 8'h01, 8'(n_reset - nr));
		chk("line before presence", 8'h01, {7'h0, early_hi});
		chk("presence", 8'h01, {7'h0, pres});
		chk("selected after reset", 8'h00, {7'h0, selected});
		chk("dq_out", 8'h00, {7'h0, dq_out});
	endtask

	task automatic test_skip();
		int nf;
		do_reset();
		mst.send_byte(8'hcc);
		chk("selected after skip", 8'h01, {7'h0, selected});
		nf = n_func;
		mst.glitch(3, 1'b1);
		mst.glitch(40, 1'b0);
		mst.send_byte(8'h96);
		chk("func byte count", 8'h01, 8'(n_func - nf));
		chk("func byte", 8'h96, last_byte);
		$display("test skip done");
	endtask

	task automatic test_match_fail();
		logic r;
		int nf;
		do_reset();
		nf = n_func;
		mst.send_byte(8'h55);
		mst.slot(DEV_ID[0], r);
		mst.slot(~DEV_ID[1], r);
		mst.slot(DEV_ID[2], r);
		mst.slot(1'b1, r);
		chk("read while asleep", 8'h01, {7'h0, r});
		chk("selected after mismatch", 8'h00, {7'h0, selected});
		chk("func bytes while asleep", 8'h00, 8'(n_func - nf));
		$display("test match mismatch done");
	endtask

	task automatic test_search();
		logic a;
		logic b;
		do_reset();
		mst.send_byte(8'hf0);
		for (int i = 0; i < 5; i++) begin
			mst.slot(1'b1, a);
			mst.slot(1'b1, b);
			chk("search bit", {7'h0, DEV_ID[i]}, {7'h0, a});
			chk("search complement", {7'h0, ~DEV_ID[i]}, {7'h0, b});
			mst.slot((i == 4) ? ~DEV_ID[i] : DEV_ID[i], a);
		end
		mst.slot(1'b1, a);
		mst.slot(1'b1, b);
		chk("bits after losing", 8'h03, {6'h0, a, b});
		chk("selected after losing", 8'h00, {7'h0, selected});
		$display("test search done");
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		chk("dq_oe after reset", 8'h00, {7'h0, dq_oe});
		test_skip();
		test_match_fail();
		test_search();
		complete_run();
	end

	// the tests need about 97000 cycles; this cuts a hang short well beyond that
	initial begin
		#3000000;
		err_count++;
		complete_run();
	end
endmodule // tb_top
